//--- hdl/cmc_cfg.svh
// Constants of the clock mode controller: offsets, fields, resets, timing.
// Assumes a 20 MHz APB clock; included by the top module.
//
// Function
// - External bypass with FLL selected keeps FLL running, unused
// - Low-power bit in internal bypass enters low-power
// - Low-power bypass turns both loops off
// - Debug request leaves internal low-power bypass
// - Low-power bit in external bypass enters low-power
// - Debug request leaves external low-power bypass
// - PLL engaged: system clock from PLL
// - Reference divider brings PLL input to 1-2 MHz
// - PLL bypass: external clock out, PLL locking
// - FLL multiplies by fixed 1024
// - One bus divider 1/2/4/8 after both loops
// - VCO multiplier in steps of four, 4-40
// - Reset starts in FLL engaged internal mode
// - Sticky loss-of-lock flag, write one clears
// - Clock monitor requests reset on lost external in external modes
// - Status fields follow select controls
`ifndef CMC_CFG_SVH
`define CMC_CFG_SVH

// Register byte offsets
`define CMC_CTRL_OFS 8'h00
`define CMC_STAT_OFS 8'h04
`define CMC_IRQ_OFS 8'h08
`define CMC_MASK_OFS 8'h0C

// Control register fields
`define CMC_CS_POS 0
`define CMC_RS_POS 2
`define CMC_LP_POS 3
`define CMC_LS_POS 4
`define CMC_REFERENCE_DIVIDER_SEL_POS 5
`define CMC_BDIV_POS 8
`define CMC_VCO_POS 10
`define CMC_CME_POS 14
`define CMC_CTRL_MASK 32'h00007FFF
`define CMC_CTRL_RST 32'h00000404

// Status register fields
`define CMC_CSS_POS 0
`define CMC_RSS_POS 2
`define CMC_LSS_POS 3
`define CMC_MODE_POS 4
`define CMC_FLK_POS 7
`define CMC_PLK_POS 8
`define CMC_BUSY_POS 9

// Interrupt status and mask bits
`define CMC_LOL_BIT 0
`define CMC_LOC_BIT 1

// Loop factors
`define CMC_FLL_MULT 11'h400
`define CMC_VCO_MIN 4'h1
`define CMC_VCO_MAX 4'hA

// Clock monitor timeout
`define CMC_CLK_PERIOD_NS 50
`define CMC_LOC_TIME_NS 10000
`define CMC_LOC_CYCLES (`CMC_LOC_TIME_NS / `CMC_CLK_PERIOD_NS)

`endif

//--- hdl/cmc_pkg.sv
// Types of the clock mode controller: modes, switch states, state records.
// Assumes cmc_cfg.svh is on the include path.
package cmc_pkg;
    typedef enum logic [2:0] {
        M_FLL_ENG_INT,
        M_FLL_ENG_EXT,
        M_FLL_BYP_INT,
        M_FLL_BYP_EXT,
        M_LP_BYP_INT,
        M_LP_BYP_EXT,
        M_PLL_ENG_EXT,
        M_PLL_BYP_EXT
    } cmc_mode_type;

    typedef enum logic [1:0] {
        SW_RUN,
        SW_DRAIN,
        SW_WAIT
    } cmc_sw_state_type;

    typedef struct packed {
        cmc_sw_state_type st;
        logic [1:0] act;
        logic [1:0] tgt;
        logic clk_out;
    } cmc_sw_type;

    typedef struct packed {
        cmc_mode_type mode;
        logic [31:0] ctrl;
        logic [1:0] irq_stat;
        logic [1:0] irq_mask;
        logic [31:0] rdata;
        logic slverr;
        logic fll_lock_q;
        logic pll_lock_q;
        logic ext_q;
        logic loop_q;
        logic [2:0] div_cnt;
        logic loop_div;
        logic [15:0] loc_cnt;
        logic loc_lost;
        logic fll_en;
        logic pll_en;
    } cmc_top_type;
endpackage : cmc_pkg

//--- hdl/cmc_sw_if.sv
// Link between the mode controller and its glitch-free output switch.
// Assumes all signals are synchronous to pclk.
`timescale 1ns/100ps
interface cmc_sw_if;
    logic [1:0] req_sel;
    logic [2:0] sources;
    logic [1:0] act_sel;
    logic busy;
    logic clk_out;

    modport ctrl (output req_sel, output sources,
                  input act_sel, input busy, input clk_out);
    modport sw (input req_sel, input sources,
                output act_sel, output busy, output clk_out);
endinterface : cmc_sw_if

//--- hdl/cmc_clk_switch.sv
// Glitch-free selector of the output clock among three sampled sources.
// Assumes source levels are synchronous to pclk; 2'h3 is never requested.
`timescale 1ns/100ps
module cmc_clk_switch (
    // Clock, reset and enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // Controller side
    cmc_sw_if.sw sw
);
    import cmc_pkg::*;

    cmc_sw_type s_reg;
    cmc_sw_type s_next;

    // Old source parked low first, new one joined while low, so
    // neither a shortened high nor a short low reaches the output
    always_comb begin
        s_next = s_reg;
        case (s_reg.st)
            SW_RUN: begin
                if (sw.req_sel != s_reg.act && !sw.sources[s_reg.act]) begin
                    s_next.st = SW_DRAIN;
                    s_next.tgt = sw.req_sel;
                end
            end
            SW_DRAIN: begin
                s_next.tgt = sw.req_sel;
                if (!sw.sources[sw.req_sel]) begin
                    s_next.st = SW_WAIT;
                end
            end
            SW_WAIT: begin
                s_next.act = s_reg.tgt;
                s_next.st = SW_RUN;
            end
            default: begin
                s_next.st = SW_RUN;
            end
        endcase
        // Output gated low while a change is under way
        s_next.clk_out = (s_next.st == SW_RUN) ?
            sw.sources[s_next.act] : 1'b0;
    end

    // State register, frozen while the clock enable is low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '{st: SW_RUN, act: 2'h0, tgt: 2'h0, clk_out: 1'b0};
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    assign sw.act_sel = s_reg.act;
    assign sw.busy = (s_reg.st != SW_RUN) || (sw.req_sel != s_reg.act);
    assign sw.clk_out = s_reg.clk_out;
endmodule : cmc_clk_switch

//--- hdl/cmc_top.sv
// Clock mode controller: APB registers, mode sequencer, bus divider,
// loss-of-lock and clock monitor, output clock selection.
// Assumes clock sources and lock flags arrive as levels synchronous
// to pclk; the analog loops themselves live outside this block.
`timescale 1ns/100ps
`include "cmc_cfg.svh"
module cmc_top #(
    parameter int LOC_CYCLES = `CMC_LOC_CYCLES
) (
    // Clock, reset and enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Clock sources and loop lock flags
    input wire logic int_ref_clk,
    input wire logic ext_ref_clk,
    input wire logic fll_clk,
    input wire logic pll_clk,
    input wire logic fll_lock,
    input wire logic pll_lock,
    // Debug port wake request
    input wire logic background_debug_port,
    // Loop controls
    output logic fll_enable,
    output logic pll_enable,
    output logic [10:0] fll_mult,
    output logic [5:0] pll_mult,
    output logic [2:0] reference_divider_sel,
    // Output clock, interrupt and reset request
    output logic sys_clk,
    output logic irq,
    output logic clock_loss_reset_req
);
    import cmc_pkg::*;

    cmc_top_type s_reg;
    cmc_top_type s_next;
    cmc_sw_if swl ();

    localparam logic [15:0] LOC_LIMIT = 16'(LOC_CYCLES);

    // Control fields
    logic [1:0] clock_source_select;
    logic reference_select;
    logic low_power_bit;
    logic loop_select;
    logic [1:0] bus_div_sel;
    logic [3:0] vco_multiplier_sel;
    logic clock_monitor_enable;
    logic loss_of_lock_irq_enable;

    // Status and helper terms
    logic reference_select_status;
    logic loop_select_status;
    logic uses_ext;
    cmc_mode_type tgt_mode;
    logic [3:0] vco_wr;
    logic setup_ph;
    logic access_ph;
    logic mapped;
    logic lol_event;
    logic loc_event;
    logic loop_lvl;
    logic [31:0] stat_word;

    // Field extraction from the control register
    assign clock_source_select = s_reg.ctrl[`CMC_CS_POS +: 2];
    assign reference_select = s_reg.ctrl[`CMC_RS_POS];
    assign low_power_bit = s_reg.ctrl[`CMC_LP_POS];
    assign loop_select = s_reg.ctrl[`CMC_LS_POS];
    assign bus_div_sel = s_reg.ctrl[`CMC_BDIV_POS +: 2];
    assign vco_multiplier_sel = s_reg.ctrl[`CMC_VCO_POS +: 4];
    assign clock_monitor_enable = s_reg.ctrl[`CMC_CME_POS];
    assign loss_of_lock_irq_enable = s_reg.irq_mask[`CMC_LOL_BIT];

    // Status derived from the current mode
    assign reference_select_status = (s_reg.mode == M_FLL_ENG_INT) ||
        (s_reg.mode == M_FLL_BYP_INT) ||
        (s_reg.mode == M_LP_BYP_INT);
    assign loop_select_status = (s_reg.mode == M_PLL_ENG_EXT) ||
        (s_reg.mode == M_PLL_BYP_EXT) ||
        ((s_reg.mode == M_LP_BYP_EXT) && loop_select);
    assign uses_ext = !reference_select_status;

    // Mode requested by the select fields, low-power aside
    always_comb begin
        if (clock_source_select == 2'h1) begin
            tgt_mode = M_FLL_BYP_INT;
        end else if (clock_source_select == 2'h2) begin
            tgt_mode = loop_select ? M_PLL_BYP_EXT : M_FLL_BYP_EXT;
        end else if (reference_select) begin
            tgt_mode = M_FLL_ENG_INT;
        end else begin
            tgt_mode = loop_select ? M_PLL_ENG_EXT : M_FLL_ENG_EXT;
        end
    end

    // Multiplier writes outside 1..10 are pulled to the nearest end
    always_comb begin
        vco_wr = pwdata[`CMC_VCO_POS +: 4];
        if (vco_wr < `CMC_VCO_MIN) begin
            vco_wr = `CMC_VCO_MIN;
        end else if (vco_wr > `CMC_VCO_MAX) begin
            vco_wr = `CMC_VCO_MAX;
        end
    end

    // APB phase decode; zero wait states unless the block is frozen
    assign setup_ph = psel && !penable;
    assign access_ph = psel && penable && ce;
    assign mapped = (paddr == `CMC_CTRL_OFS) ||
        (paddr == `CMC_STAT_OFS) || (paddr == `CMC_IRQ_OFS) ||
        (paddr == `CMC_MASK_OFS);

    // Loop clock seen through the shared bus divider
    assign loop_lvl = loop_select_status ? pll_clk : fll_clk;

    // A running loop dropping out of lock is an event
    assign lol_event = (s_reg.fll_en && s_reg.fll_lock_q && !fll_lock) ||
        (s_reg.pll_en && s_reg.pll_lock_q && !pll_lock);
    // Monitor expiry in an external mode is an event; taken from the
    // present state and inputs, not s_next, so the next-state process sees no loop
    assign loc_event = (ext_ref_clk == s_reg.ext_q) && !s_reg.loc_lost &&
        (s_reg.loc_cnt + 16'h0001 >= LOC_LIMIT) &&
        clock_monitor_enable && uses_ext;

    // Status word as software reads it
    always_comb begin
        stat_word = 32'h00000000;
        stat_word[`CMC_CSS_POS +: 2] = swl.act_sel;
        stat_word[`CMC_RSS_POS] = reference_select_status;
        stat_word[`CMC_LSS_POS] = loop_select_status;
        stat_word[`CMC_MODE_POS +: 3] = s_reg.mode;
        stat_word[`CMC_FLK_POS] = fll_lock;
        stat_word[`CMC_PLK_POS] = pll_lock;
        stat_word[`CMC_BUSY_POS] = swl.busy;
    end

    // Next state of the whole block
    always_comb begin
        s_next = s_reg;

        // Mode sequencer
        case (s_reg.mode)
            M_LP_BYP_INT: begin
                if (background_debug_port || !low_power_bit) begin
                    s_next.mode = M_FLL_BYP_INT;
                end
            end
            M_LP_BYP_EXT: begin
                // Loop select may change here; exit picks the new loop
                if (background_debug_port || !low_power_bit) begin
                    s_next.mode = loop_select ?
                        M_PLL_BYP_EXT : M_FLL_BYP_EXT;
                end
            end
            default: begin
                s_next.mode = tgt_mode;
                if (low_power_bit && !background_debug_port) begin
                    if (s_reg.mode == M_FLL_BYP_INT &&
                        tgt_mode == M_FLL_BYP_INT) begin
                        s_next.mode = M_LP_BYP_INT;
                    end else if ((s_reg.mode == M_FLL_BYP_EXT ||
                        s_reg.mode == M_PLL_BYP_EXT) &&
                        (tgt_mode == M_FLL_BYP_EXT ||
                        tgt_mode == M_PLL_BYP_EXT)) begin
                        s_next.mode = M_LP_BYP_EXT;
                    end
                end
            end
        endcase

        // Loop enables follow the mode being entered
        s_next.fll_en = 1'b0;
        s_next.pll_en = 1'b0;
        case (s_next.mode)
            M_LP_BYP_INT, M_LP_BYP_EXT: begin
                s_next.fll_en = 1'b0;
                s_next.pll_en = 1'b0;
            end
            M_PLL_ENG_EXT, M_PLL_BYP_EXT: begin
                s_next.pll_en = 1'b1;
            end
            M_FLL_BYP_EXT, M_FLL_BYP_INT: begin
                s_next.fll_en = 1'b1;
            end
            default: begin
                s_next.fll_en = 1'b1;
            end
        endcase

        // Bus divider counts rising edges of the loop clock
        s_next.loop_q = loop_lvl;
        if (loop_lvl && !s_reg.loop_q) begin
            s_next.div_cnt = s_reg.div_cnt + 3'h1;
        end
        case (bus_div_sel)
            2'h0: s_next.loop_div = loop_lvl;
            2'h1: s_next.loop_div = s_next.div_cnt[0];
            2'h2: s_next.loop_div = s_next.div_cnt[1];
            default: s_next.loop_div = s_next.div_cnt[2];
        endcase

        // Lock history for the loss-of-lock edge
        s_next.fll_lock_q = fll_lock;
        s_next.pll_lock_q = pll_lock;

        // Clock monitor: cycles since the last external edge
        s_next.ext_q = ext_ref_clk;
        if (ext_ref_clk != s_reg.ext_q) begin
            s_next.loc_cnt = 16'h0000;
        end else if (s_reg.loc_cnt < LOC_LIMIT) begin
            s_next.loc_cnt = s_reg.loc_cnt + 16'h0001;
        end
        s_next.loc_lost = (s_next.loc_cnt >= LOC_LIMIT);

        // Register writes, taken in the access phase
        if (access_ph && pwrite) begin
            case (paddr)
                `CMC_CTRL_OFS: begin
                    s_next.ctrl = pwdata & `CMC_CTRL_MASK;
                    s_next.ctrl[`CMC_VCO_POS +: 4] = vco_wr;
                end
                `CMC_IRQ_OFS: begin
                    s_next.irq_stat = s_reg.irq_stat & ~pwdata[1:0];
                end
                `CMC_MASK_OFS: begin
                    s_next.irq_mask = pwdata[1:0];
                end
                default: begin
                    s_next.irq_mask = s_reg.irq_mask;
                end
            endcase
        end

        // Events set after the clear so a same-cycle event survives
        if (lol_event) begin
            s_next.irq_stat[`CMC_LOL_BIT] = 1'b1;
        end
        if (loc_event) begin
            s_next.irq_stat[`CMC_LOC_BIT] = 1'b1;
        end

        // Read data captured in the setup phase
        if (setup_ph) begin
            s_next.slverr = !mapped;
            case (paddr)
                `CMC_CTRL_OFS: s_next.rdata = s_reg.ctrl;
                `CMC_STAT_OFS: s_next.rdata = stat_word;
                `CMC_IRQ_OFS: s_next.rdata = {30'h0, s_reg.irq_stat};
                `CMC_MASK_OFS: s_next.rdata = {30'h0, s_reg.irq_mask};
                default: s_next.rdata = 32'h00000000;
            endcase
        end
    end

    // One register for all state; reset lands in FLL engaged internal
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
            s_reg.mode <= M_FLL_ENG_INT;
            s_reg.ctrl <= `CMC_CTRL_RST;
            s_reg.fll_en <= 1'b1;
        end else if (ce) begin
            s_reg <= s_next;
        end
    end

    // Output switch request per mode: loop, internal or external
    always_comb begin
        case (s_reg.mode)
            M_FLL_BYP_INT, M_LP_BYP_INT: swl.req_sel = 2'h1;
            M_FLL_BYP_EXT, M_PLL_BYP_EXT, M_LP_BYP_EXT: begin
                swl.req_sel = 2'h2;
            end
            default: swl.req_sel = 2'h0;
        endcase
    end
    assign swl.sources = {ext_ref_clk, int_ref_clk, s_reg.loop_div};

    cmc_clk_switch u_switch (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .sw(swl.sw)
    );

    // APB answers
    assign prdata = s_reg.rdata;
    assign pready = ce;
    assign pslverr = s_reg.slverr && psel && penable;

    // Loop and clock outputs
    assign fll_enable = s_reg.fll_en;
    assign pll_enable = s_reg.pll_en;
    assign fll_mult = `CMC_FLL_MULT;
    assign pll_mult = {vco_multiplier_sel, 2'h0};
    assign reference_divider_sel =
        s_reg.ctrl[`CMC_REFERENCE_DIVIDER_SEL_POS +: 3];
    assign sys_clk = swl.clk_out;

    // Interrupt level from unmasked sticky bits
    assign irq = |(s_reg.irq_stat & s_reg.irq_mask);
    // Reset request only where the external reference is in use
    assign clock_loss_reset_req = s_reg.loc_lost &&
        clock_monitor_enable && uses_ext;
endmodule : cmc_top

//--- sim/cmc_properties.sv
// Concurrent checks on the ports of the clock mode controller.
// Assumes one pclk domain and an active-low asynchronous presetn.
`timescale 1ns/100ps
module cmc_properties (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // Sources and controls
    input wire logic ext_ref_clk,
    input wire logic background_debug_port,
    input wire logic fll_enable,
    input wire logic pll_enable,
    input wire logic [10:0] fll_mult,
    input wire logic [5:0] pll_mult,
    input wire logic [2:0] reference_divider_sel,
    input wire logic irq,
    input wire logic clock_loss_reset_req
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Steps of a debug wake and of a running reference
    sequence s_dbg_held;
        background_debug_port [*3];
    endsequence
    sequence s_toggle;
        ext_ref_clk != $past(ext_ref_clk);
    endsequence

    // Loop factors and enables
    chk_fll_fixed: assert property (fll_mult == 11'h400)
        else $error("fll multiplier not fixed");
    chk_vco_steps: assert property (pll_mult[1:0] == 2'h0 &&
        pll_mult >= 6'h04 && pll_mult <= 6'h28)
        else $error("pll multiplier out of steps");
    chk_loops_apart: assert property (!(fll_enable && pll_enable))
        else $error("both loops enabled");
    chk_debug_wake: assert property (s_dbg_held |->
        (fll_enable || pll_enable))
        else $error("debug request left loops off");
    // Fields move only on a control write
    chk_reference_divider_sel_write: assert property ($changed(reference_divider_sel) |->
        $past(psel && penable && pwrite && ce && paddr == 8'h00))
        else $error("divider changed without write");
    chk_vco_write: assert property ($changed(pll_mult) |->
        $past(psel && penable && pwrite && ce && paddr == 8'h00))
        else $error("multiplier changed without write");
    // Sticky interrupt falls only by software
    chk_irq_clear: assert property ($fell(irq) |->
        $past(psel && penable && pwrite && ce))
        else $error("irq fell without write");
    // A running reference never reports loss
    chk_monitor_run: assert property (s_toggle [*3] |->
        !clock_loss_reset_req)
        else $error("loss reported on running clock");
    // Bus answer
    chk_ready_ce: assert property (pready == ce)
        else $error("pready differs from ce");
    chk_err_access: assert property (pslverr |-> psel && penable)
        else $error("error outside access");
endmodule : cmc_properties

//--- sim/tb_top.sv
// Self-checking bench of the clock mode controller over APB.
// Assumes cmc_cfg.svh on the include path; monitor count shortened to 8.
`timescale 1ns/100ps
module tb_top;
    // Design ports and bench state
    logic pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd, seed = 32'h84113942;
    logic pready, pslverr, er, sq, ext_q, ext_run = 1;
    logic int_ref_clk = 0, ext_ref_clk = 0, fll_clk = 0, pll_clk = 0;
    logic fll_lock = 1, pll_lock = 1, background_debug_port = 0;
    logic fll_enable, pll_enable, sys_clk, irq, clock_loss_reset_req;
    logic [10:0] fll_mult;
    logic [5:0] pll_mult;
    logic [2:0] reference_divider_sel;
    logic [2:0] cnt = 3'h0;
    int num_errors = 0, checks = 0, n, v, m;

    cmc_top #(.LOC_CYCLES(8)) i_cmc_top (.pclk, .presetn, .ce, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .int_ref_clk, .ext_ref_clk, .fll_clk, .pll_clk, .fll_lock,
        .pll_lock, .background_debug_port, .fll_enable, .pll_enable,
        .fll_mult, .pll_mult, .reference_divider_sel, .sys_clk, .irq,
        .clock_loss_reset_req);

    // Clock, then sources; internal and FLL at distinct rates, PLL and external at one rate
    initial forever #25 pclk = ~pclk;
    always @(posedge pclk) begin
        cnt <= cnt + 3'h1;
        int_ref_clk <= cnt[1];
        fll_clk <= cnt[2];
        pll_clk <= ~cnt[0];
        ext_q <= ext_ref_clk;
        if (ext_run) ext_ref_clk <= cnt[0];
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task tick(input int k);
        repeat (k) @(posedge pclk);
    endtask : tick

    // One APB transfer; waits for pready, only the watchdog ends a stall
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb

    // Software side polls status until the mode settles
    task poll(input int mode);
        for (int i = 0; i < 40; i++) begin
            apb(0, 8'h04, 0);
            if (rd[6:4] == mode && !rd[9]) break;
        end
        chk({rd[9], rd[6:4]}, mode);
    endtask : poll

    task wrap_up;
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : wrap_up

    // Watchdog against a hung handshake
    initial begin
        tick(20000);
        num_errors++;
        wrap_up;
    end

    // Main sequence
    initial begin
        tick(4);
        presetn <= 1;
        apb(0, 8'h00, 0);
        chk(rd, 32'h00000404);
        poll(0);
        chk(rd[2], 1);
        chk({fll_enable, pll_enable, pll_mult}, {2'b10, 6'h04});
        chk(fll_mult, 32'h400);
        // Unmapped read refused, status write ignored
        apb(0, 8'h10, 0);
        chk(er, 1);
        chk(rd, 0);
        apb(1, 8'h04, 32'hFFFFFFFF);
        poll(0);
        // Multiplier clamped to 1..10, ends included
        for (int i = 0; i < 10; i++) begin
            v = (i < 2) ? i * 15 : xs() & 15;
            m = (v < 1) ? 1 : (v > 10) ? 10 : v;
            apb(1, 8'h00, 32'h004 | (v << 10));
            apb(0, 8'h00, 0);
            chk(rd, 32'h004 | (m << 10));
            chk(pll_mult, m * 4);
        end
        // Internal bypass, low power and debug wake
        apb(1, 8'h00, 32'h405);
        poll(2);
        chk(fll_enable, 1);
        apb(1, 8'h00, 32'h40D);
        poll(4);
        chk({fll_enable, pll_enable}, 0);
        background_debug_port <= 1;
        poll(2);
        chk(fll_enable, 1);
        background_debug_port <= 0;
        poll(4);
        // External bypass drives the output one cycle late
        apb(1, 8'h00, 32'h402);
        poll(3);
        chk(rd[1:0], 2);
        chk(fll_enable, 1);
        repeat (8) begin
            tick(1);
            #1;
            chk(sys_clk, ext_q);
        end
        apb(1, 8'h00, 32'h40A);
        poll(5);
        chk({fll_enable, pll_enable}, 0);
        background_debug_port <= 1;
        poll(3);
        background_debug_port <= 0;
        poll(5);
        // Loop and divider changed while low power, then PLL modes
        apb(1, 8'h00, 32'h47A);
        poll(5);
        chk(reference_divider_sel, 3);
        apb(1, 8'h00, 32'h472);
        poll(7);
        chk({fll_enable, pll_enable}, 1);
        apb(1, 8'h00, 32'h470);
        poll(6);
        chk(rd[1:0], 0);
        // Bus divider rates on the loop path
        for (int b = 0; b < 4; b++) begin
            apb(1, 8'h00, 32'h470 | (b << 8));
            tick(8);
            n = 0;
            sq = sys_clk;
            repeat (64) begin
                tick(1);
                #1;
                if (sys_clk && !sq) n++;
                sq = sys_clk;
            end
            chk(n >= (32 >> b) - 1 && n <= (32 >> b) + 1, 1);
        end
        // Loss of lock: sticky, masked, write-one clear
        apb(1, 8'h00, 32'h470);
        pll_lock <= 0;
        tick(3);
        apb(0, 8'h08, 0);
        chk(rd, 1);
        chk(irq, 0);
        apb(1, 8'h0C, 1);
        tick(1);
        #1;
        chk(irq, 1);
        apb(1, 8'h08, 1);
        tick(1);
        #1;
        chk(irq, 0);
        apb(0, 8'h08, 0);
        chk(rd, 0);
        pll_lock <= 1;
        // Clock monitor on a stopped reference
        apb(1, 8'h00, 32'h4470);
        ext_run <= 0;
        tick(16);
        #1;
        chk(clock_loss_reset_req, 1);
        ext_run <= 1;
        tick(4);
        #1;
        chk(clock_loss_reset_req, 0);
        apb(1, 8'h08, 3);
        // FLL engaged external, then a frozen clock enable
        apb(1, 8'h00, 32'h400);
        poll(1);
        chk({rd[3:2], fll_enable, pll_enable}, 4'b0010);
        ce <= 0;
        tick(1);
        #1;
        sq = sys_clk;
        tick(4);
        #1;
        chk({pready, sys_clk}, {1'b0, sq});
        tick(1);
        ce <= 1;
        // Low-power bit outside bypass has no effect
        apb(1, 8'h00, 32'h40C);
        poll(0);
        chk(fll_enable, 1);
        wrap_up;
    end
endmodule : tb_top

bind cmc_top cmc_properties i_cmc_properties (.pclk, .presetn, .ce, .psel,
    .penable, .pwrite, .paddr, .pready, .pslverr, .ext_ref_clk,
    .background_debug_port, .fll_enable, .pll_enable, .fll_mult,
    .pll_mult, .reference_divider_sel, .irq, .clock_loss_reset_req);
